// ===== shared/timer_pkg.sv
package timer_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00; // run, mode, reload, update
	localparam logic [7:0] OFF_PRESC  = 8'h04; // prescaler value
	localparam logic [7:0] OFF_LOAD   = 8'h08; // period, shadowed
	localparam logic [7:0] OFF_REPEAT = 8'h0C; // repeat count
	localparam logic [7:0] OFF_CCMODE = 8'h10; // two bits per pin channel
	localparam logic [7:0] OFF_DEADB  = 8'h14; // rise [7:0], fall [15:8]
	localparam logic [7:0] OFF_FAULT  = 8'h18; // safe p/n [7:0], enable [8]
	localparam logic [7:0] OFF_TRIG   = 8'h1C; // source [4:0], enable [5]
	localparam logic [7:0] OFF_STATUS = 8'h20; // sticky, clear on read
	localparam logic [7:0] OFF_MASK   = 8'h24; // interrupt mask
	localparam logic [7:0] OFF_COUNT  = 8'h28; // live count, read only
	localparam logic [7:0] OFF_OUTEN  = 8'h2C; // dma [0], adc trigger [1]
	localparam logic [7:0] OFF_CC0    = 8'h40; // six compare words follow
	// ----------------------------------------------------------------
	// sizes and field positions
	// ----------------------------------------------------------------
	localparam int NCH     = 6; // four pin channels plus two internal
	localparam int NPIN    = 4; // channels that reach pins
	localparam int CTL_EN  = 0; // counter run
	localparam int CTL_MD  = 1; // count mode, two bits
	localparam int CTL_RLD = 3; // repeat-reload
	localparam int CTL_UPD = 4; // shadow update enable
	localparam int FLT_EN  = 8; // fault input enable
	localparam int TRG_EN  = 5; // cross trigger enable
	localparam int ST_PER  = 0; // period event
	localparam int ST_CC   = 1; // six channel events from here
	localparam int ST_FLT  = 7; // fault seen
	localparam int ST_TRG  = 8; // cross trigger taken
	localparam int STW     = 9; // status width
	// ----------------------------------------------------------------
	// reset values and trigger sources
	// ----------------------------------------------------------------
	localparam logic [15:0] LOAD_RST  = 16'hFFFF; // full period
	localparam logic [31:0] ZERO_RST  = 32'h0000_0000; // other registers
	localparam logic [4:0]  TSEL_SUB0 = 5'h10; // event subscriber zero
	localparam logic [4:0]  TSEL_SUB1 = 5'h11; // event subscriber one
	localparam logic [4:0]  TSEL_PEER = 5'h06; // peers below this
	// ----------------------------------------------------------------
	// modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {CM_DOWN, CM_UP, CM_UPDOWN, CM_RSVD} cnt_mode_t;
	typedef enum logic [1:0] {CC_COMPARE, CC_CAPTURE, CC_PWM, CC_ONESHOT}
		cc_mode_t;
endpackage

// ===== shared/deadband_if.sv
`timescale 1ns/1ps
`default_nettype none
interface deadband_if;
	logic [3:0] raw;     // undelayed pwm per pin channel
	logic [7:0] rise;    // delay before the high side turns on
	logic [7:0] fall;    // delay before the low side turns on
	logic       fault;   // force safe levels
	logic [7:0] safe;    // safe p [3:0], safe n [7:4]
	logic [3:0] out_p;   // high-side output
	logic [3:0] out_n;   // complementary output
	modport core (output raw, rise, fall, fault, safe, input out_p, out_n);
	modport gen  (input raw, rise, fall, fault, safe, output out_p, out_n);
endinterface
`default_nettype wire

// ===== logic/deadband_gen.sv
`timescale 1ns/1ps
`default_nettype none
module deadband_gen
	import timer_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rstn,
	deadband_if.gen   db
);
	logic [7:0] cnt_r   [NPIN]; // cycles since the last raw edge
	logic [7:0] cnt_nxt [NPIN];
	logic [3:0] raw_r, raw_nxt;  // previous raw level
	logic [3:0] p_r, p_nxt;      // registered high side
	logic [3:0] n_r, n_nxt;      // registered low side

	// ----------------------------------------------------------------
	// edge delay per channel
	// ----------------------------------------------------------------
	// both sides are off during the delay, so outside a fault the pair never overlaps
	always_comb
	begin
		raw_nxt = db.raw;
		for (int i = 0; i < NPIN; i++)
		begin
			// restart the delay on any edge, saturate otherwise
			if (db.raw[i] != raw_r[i])
				cnt_nxt[i] = 8'h00;
			else if (cnt_r[i] != 8'hFF)
				cnt_nxt[i] = cnt_r[i] + 8'h01;
			else
				cnt_nxt[i] = cnt_r[i];
			p_nxt[i] = db.raw[i] & (cnt_nxt[i] >= db.rise);
			n_nxt[i] = ~db.raw[i] & (cnt_nxt[i] >= db.fall);
		end
		// fault overrides whatever the pwm wants
		if (db.fault)
		begin
			p_nxt = db.safe[3:0];
			n_nxt = db.safe[7:4];
		end
	end

	// registers only
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			raw_r <= 4'h0;
			p_r   <= 4'h0;
			n_r   <= 4'h0;
			for (int i = 0; i < NPIN; i++)
				cnt_r[i] <= 8'h00;
		end
		else
		begin
			raw_r <= raw_nxt;
			p_r   <= p_nxt;
			n_r   <= n_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign db.out_p = p_r;
	assign db.out_n = n_r;
endmodule
`default_nettype wire

// ===== logic/pwm_timer.sv
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pwm_timer
	import timer_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  cap_in,
	input  wire logic        fault_in,
	input  wire logic [5:0]  peer_trig,
	input  wire logic        event_subscriber_port_zero,
	input  wire logic        event_subscriber_port_one,
	output logic      [3:0]  pwm_p,
	output logic      [3:0]  pwm_n,
	output logic             irq,
	output logic             dma_req,
	output logic             adc_trig,
	output logic             primary_trigger_output
);
	import timer_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// pick the cross trigger source; reserved codes give no trigger
	function automatic logic trig_pick(input logic [4:0] s,
		input logic [5:0] peers, input logic s0, input logic s1);
		if (s < TSEL_PEER)
			return peers[s[2:0]];
		else if (s == TSEL_SUB0)
			return s0;
		else if (s == TSEL_SUB1)
			return s1;
		return 1'b0;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [5:0]  ctrl_r, ctrl_nxt;     // control bits
	logic [7:0]  presc_r, presc_nxt;   // prescaler value
	logic [15:0] load_r, load_nxt;     // shadow period
	logic [7:0]  rep_r, rep_nxt;       // repeat count
	logic [7:0]  ccm_r, ccm_nxt;       // pin channel modes
	logic [15:0] deadb_r, deadb_nxt;   // dead band delays
	logic [8:0]  flt_r, flt_nxt;       // safe levels, enable
	logic [5:0]  trg_r, trg_nxt;       // trigger select, enable
	logic [STW-1:0] st_r, st_nxt;      // sticky events
	logic [STW-1:0] mask_r, mask_nxt;  // interrupt mask
	logic [1:0]  oen_r, oen_nxt;       // dma and adc enables
	logic [15:0] cc_r   [NCH];         // shadow compare values
	logic [15:0] cc_nxt [NCH];
	logic [31:0] rd_r, rd_nxt;         // read data
	logic        err_r, err_nxt;       // unmapped address seen

	logic [15:0] cnt_r, cnt_nxt;       // the counter
	logic [7:0]  pre_r, pre_nxt;       // prescaler count
	logic [7:0]  rcnt_r, rcnt_nxt;     // repeat progress
	logic        dir_r, dir_nxt;       // up-down: counting up
	logic        run_r, run_nxt;       // counter running
	logic [15:0] lact_r, lact_nxt;     // active period
	logic [15:0] cact_r [NCH];         // active compare values
	logic [15:0] cact_nxt [NCH];
	logic [15:0] cap_r  [NPIN];        // captured counts
	logic [15:0] cap_nxt [NPIN];
	logic [3:0]  out_r, out_nxt;       // raw channel levels
	logic        trg_d_r;              // last trigger level
	logic [3:0]  cs1_r, cs2_r, cs3_r;  // capture sync and edge
	logic        fs1_r, fs2_r;         // fault sync
	logic        dma_r, dma_nxt;       // dma pulse
	logic        adc_r, adc_nxt;       // adc pulse
	logic        ptrg_r, ptrg_nxt;     // primary trigger pulse

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic        setup, wr, rd_acc;
	logic        tick, wrap, per_ev, trg_ev;
	logic [5:0]  ev;
	logic [3:0]  cap_edge;
	logic        trg_now;
	cnt_mode_t   cmode;

	assign setup  = psel & ~penable;
	assign wr     = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign pready = psel & penable; // zero wait states
	assign cmode  = cnt_mode_t'(ctrl_r[CTL_MD +: 2]);
	assign cap_edge = cs2_r & ~cs3_r;
	assign trg_now  = trig_pick(trg_r[4:0], peer_trig,
		event_subscriber_port_zero, event_subscriber_port_one);
	assign trg_ev   = trg_r[TRG_EN] & trg_now & ~trg_d_r;

	deadband_if db ();

	// register file next values
	always_comb
	begin
		ctrl_nxt  = ctrl_r;
		presc_nxt = presc_r;
		load_nxt  = load_r;
		rep_nxt   = rep_r;
		ccm_nxt   = ccm_r;
		deadb_nxt = deadb_r;
		flt_nxt   = flt_r;
		trg_nxt   = trg_r;
		mask_nxt  = mask_r;
		oen_nxt   = oen_r;
		cc_nxt    = cc_r;
		rd_nxt    = rd_r;
		err_nxt   = err_r;
		// read data is taken in setup so it leaves a flip-flop
		if (setup)
		begin
			rd_nxt  = ZERO_RST;
			err_nxt = 1'b0;
			unique case (paddr)
			// run bit reads back live, so a trigger start is visible
			OFF_CTRL:   rd_nxt[5:0]  = {ctrl_r[5:1], run_r};
			OFF_PRESC:  rd_nxt[7:0]  = presc_r;
			OFF_LOAD:   rd_nxt[15:0] = load_r;
			OFF_REPEAT: rd_nxt[7:0]  = rep_r;
			OFF_CCMODE: rd_nxt[7:0]  = ccm_r;
			OFF_DEADB:  rd_nxt[15:0] = deadb_r;
			OFF_FAULT:  rd_nxt[8:0]  = flt_r;
			OFF_TRIG:   rd_nxt[5:0]  = trg_r;
			OFF_STATUS: rd_nxt[STW-1:0] = st_r;
			OFF_MASK:   rd_nxt[STW-1:0] = mask_r;
			OFF_COUNT:  rd_nxt[15:0] = cnt_r;
			OFF_OUTEN:  rd_nxt[1:0]  = oen_r;
			default:
			begin
				err_nxt = 1'b1;
				for (int i = 0; i < NCH; i++)
					if (paddr == OFF_CC0 + 8'(4 * i))
					begin
						err_nxt = 1'b0;
						// capture channels show the captured count
						if (i < NPIN && ccm_r[2*i +: 2] == CC_CAPTURE)
							rd_nxt[15:0] = cap_r[i];
						else
							rd_nxt[15:0] = cc_r[i];
					end
			end
			endcase
		end
		// writes land at the access edge only
		if (wr)
		begin
			unique case (paddr)
			OFF_CTRL:   ctrl_nxt  = pwdata[5:0];
			OFF_PRESC:  presc_nxt = pwdata[7:0];
			OFF_LOAD:   load_nxt  = pwdata[15:0];
			OFF_REPEAT: rep_nxt   = pwdata[7:0];
			OFF_CCMODE: ccm_nxt   = pwdata[7:0];
			OFF_DEADB:  deadb_nxt = pwdata[15:0];
			OFF_FAULT:  flt_nxt   = pwdata[8:0];
			OFF_TRIG:   trg_nxt   = pwdata[5:0];
			OFF_MASK:   mask_nxt  = pwdata[STW-1:0];
			OFF_OUTEN:  oen_nxt   = pwdata[1:0];
			default:
				for (int i = 0; i < NCH; i++)
					if (paddr == OFF_CC0 + 8'(4 * i))
						cc_nxt[i] = pwdata[15:0];
			endcase
		end
	end

	// ----------------------------------------------------------------
	// counter, prescaler, repeat and shadow transfer
	// ----------------------------------------------------------------
	always_comb
	begin
		cnt_nxt  = cnt_r;
		pre_nxt  = pre_r;
		rcnt_nxt = rcnt_r;
		dir_nxt  = dir_r;
		run_nxt  = run_r;
		lact_nxt = lact_r;
		cact_nxt = cact_r;
		tick     = 1'b0;
		wrap     = 1'b0;
		per_ev   = 1'b0;
		// software start or stop follows the run bit
		if (wr && paddr == OFF_CTRL)
			run_nxt = pwdata[CTL_EN];
		if (run_r)
		begin
			// divide by value plus one; zero passes every cycle
			if (pre_r == presc_r)
			begin
				pre_nxt = 8'h00;
				tick    = 1'b1;
			end
			else
				pre_nxt = pre_r + 8'h01;
		end
		if (tick)
		begin
			unique case (cmode)
			CM_UP:
				if (cnt_r == lact_r)
				begin
					cnt_nxt = 16'h0000;
					wrap    = 1'b1;
				end
				else
					cnt_nxt = cnt_r + 16'h0001;
			CM_UPDOWN:
				if (dir_r)
				begin
					dir_nxt = (cnt_r != lact_r);
					cnt_nxt = (cnt_r == lact_r) ? cnt_r - 16'h0001
						: cnt_r + 16'h0001;
				end
				else if (cnt_r == 16'h0000)
				begin
					dir_nxt = 1'b1;
					cnt_nxt = 16'h0001;
					wrap    = 1'b1;
				end
				else
					cnt_nxt = cnt_r - 16'h0001;
			default: // down; the spare code also counts down
				if (cnt_r == 16'h0000)
				begin
					cnt_nxt = lact_r;
					wrap    = 1'b1;
				end
				else
					cnt_nxt = cnt_r - 16'h0001;
			endcase
		end
		if (wrap)
		begin
			// without repeat-reload the counter stops after one period
			if (!ctrl_r[CTL_RLD])
				run_nxt = 1'b0;
			// period end is the only moment shadows move
			if (ctrl_r[CTL_UPD])
			begin
				lact_nxt = load_r;
				cact_nxt = cc_r;
			end
			if (rcnt_r == rep_r)
			begin
				rcnt_nxt = 8'h00;
				per_ev   = 1'b1;
			end
			else
				rcnt_nxt = rcnt_r + 8'h01;
		end
		// a cross trigger restarts the period from its start
		if (trg_ev)
		begin
			run_nxt  = 1'b1;
			pre_nxt  = 8'h00;
			rcnt_nxt = 8'h00;
			dir_nxt  = 1'b1;
			cnt_nxt  = (cmode == CM_DOWN) ? lact_r : 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// channels, events and status
	// ----------------------------------------------------------------
	always_comb
	begin
		cap_nxt = cap_r;
		out_nxt = out_r;
		ev      = 6'h00;
		for (int i = 0; i < NCH; i++)
		begin
			// internal channels only compare
			if (i >= NPIN)
				ev[i] = tick & (cnt_r == cact_r[i]);
			else
				unique case (cc_mode_t'(ccm_r[2*i +: 2]))
				CC_CAPTURE:
					if (cap_edge[i])
					begin
						cap_nxt[i] = cnt_r;
						ev[i]      = 1'b1;
					end
				CC_COMPARE:
				begin
					ev[i] = tick & (cnt_r == cact_r[i]);
					if (ev[i])
						out_nxt[i] = ~out_r[i];
				end
				CC_PWM:
				begin
					ev[i]      = tick & (cnt_r == cact_r[i]);
					out_nxt[i] = (cnt_r < cact_r[i]);
				end
				CC_ONESHOT:
				begin
					ev[i] = tick & (cnt_r == cact_r[i]);
					if (ev[i])
						out_nxt[i] = 1'b1;
				end
				endcase
		end
		// a mode write rearms one-shot and compare outputs
		if (wr && paddr == OFF_CCMODE)
			out_nxt = 4'h0;
		// set wins over the read clear of the same bit
		st_nxt = st_r;
		if (rd_acc && paddr == OFF_STATUS)
			st_nxt = st_r & ~rd_r[STW-1:0];
		st_nxt[ST_PER] = st_nxt[ST_PER] | per_ev;
		st_nxt[ST_CC +: NCH] = st_nxt[ST_CC +: NCH] | ev;
		st_nxt[ST_FLT] = st_nxt[ST_FLT] | db.fault;
		st_nxt[ST_TRG] = st_nxt[ST_TRG] | trg_ev;
		dma_nxt  = oen_r[0] & per_ev;
		adc_nxt  = oen_r[1] & (per_ev | ev[4]);
		ptrg_nxt = per_ev;
	end

	// all registers, one clocked process
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			ctrl_r  <= 6'h00;
			presc_r <= 8'h00;
			load_r  <= LOAD_RST;
			rep_r   <= 8'h00;
			ccm_r   <= 8'h00;
			deadb_r <= 16'h0000;
			flt_r   <= 9'h000;
			trg_r   <= 6'h00;
			st_r    <= '0;
			mask_r  <= '0;
			oen_r   <= 2'h0;
			rd_r    <= ZERO_RST;
			err_r   <= 1'b0;
			cnt_r   <= 16'h0000;
			pre_r   <= 8'h00;
			rcnt_r  <= 8'h00;
			dir_r   <= 1'b1;
			run_r   <= 1'b0;
			lact_r  <= LOAD_RST;
			out_r   <= 4'h0;
			trg_d_r <= 1'b0;
			cs1_r   <= 4'h0;
			cs2_r   <= 4'h0;
			cs3_r   <= 4'h0;
			fs1_r   <= 1'b0;
			fs2_r   <= 1'b0;
			dma_r   <= 1'b0;
			adc_r   <= 1'b0;
			ptrg_r  <= 1'b0;
			for (int i = 0; i < NCH; i++)
			begin
				cc_r[i]   <= 16'h0000;
				cact_r[i] <= 16'h0000;
			end
			for (int i = 0; i < NPIN; i++)
				cap_r[i] <= 16'h0000;
		end
		else
		begin
			ctrl_r  <= ctrl_nxt;
			presc_r <= presc_nxt;
			load_r  <= load_nxt;
			rep_r   <= rep_nxt;
			ccm_r   <= ccm_nxt;
			deadb_r <= deadb_nxt;
			flt_r   <= flt_nxt;
			trg_r   <= trg_nxt;
			st_r    <= st_nxt;
			mask_r  <= mask_nxt;
			oen_r   <= oen_nxt;
			rd_r    <= rd_nxt;
			err_r   <= err_nxt;
			cc_r    <= cc_nxt;
			cnt_r   <= cnt_nxt;
			pre_r   <= pre_nxt;
			rcnt_r  <= rcnt_nxt;
			dir_r   <= dir_nxt;
			run_r   <= run_nxt;
			lact_r  <= lact_nxt;
			cact_r  <= cact_nxt;
			cap_r   <= cap_nxt;
			out_r   <= out_nxt;
			trg_d_r <= trg_now;
			cs1_r   <= cap_in;
			cs2_r   <= cs1_r;
			cs3_r   <= cs2_r;
			fs1_r   <= fault_in;
			fs2_r   <= fs1_r;
			dma_r   <= dma_nxt;
			adc_r   <= adc_nxt;
			ptrg_r  <= ptrg_nxt;
		end
	end

	// ----------------------------------------------------------------
	// output stage
	// ----------------------------------------------------------------
	assign db.raw   = out_r;
	assign db.rise  = deadb_r[7:0];
	assign db.fall  = deadb_r[15:8];
	assign db.fault = fs2_r & flt_r[FLT_EN];
	assign db.safe  = flt_r[7:0];

	deadband_gen u_db (
		.mclk (mclk),
		.rstn (rstn),
		.db   (db)
	);

	assign pwm_p   = db.out_p;
	assign pwm_n   = db.out_n;
	assign prdata  = rd_r;
	assign pslverr = pready & err_r;
	assign irq     = |(st_r & mask_r);
	assign dma_req = dma_r;
	assign adc_trig = adc_r;
	assign primary_trigger_output = ptrg_r;
endmodule
`default_nettype wire

// ===== testbench/pwm_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_monitor
	import timer_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        fault_in,
	input wire logic [3:0]  pwm_p,
	input wire logic [3:0]  pwm_n,
	input wire logic        irq,
	input wire logic        dma_req
);
	// ------------------------------------------------
	// copies of the fields the checks depend on
	// ------------------------------------------------
	logic           wr_acc;   // write lands at this edge
	logic           clr_ev;   // status read or mask write
	logic           rd_cnt;   // live count being read
	logic [8:0]     flt_r;    // safe levels and enable
	logic [STW-1:0] mask_r;   // interrupt mask
	logic [7:0]     rise_r;   // high-side turn-on delay
	logic [7:0]     fall_r;   // low-side turn-on delay
	logic [7:0]     nlow_cnt; // cycles pwm_n[0] stayed low
	logic [7:0]     plow_cnt; // cycles pwm_p[0] stayed low
	assign wr_acc = psel && penable && pwrite;
	assign rd_cnt = psel && penable && !pwrite && paddr == OFF_COUNT;
	assign clr_ev = psel && penable
		&& (pwrite ? paddr == OFF_MASK : paddr == OFF_STATUS);
	// counters saturate so a long idle stretch cannot wrap to zero
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			flt_r    <= 9'h000;
			mask_r   <= '0;
			rise_r   <= 8'h00;
			fall_r   <= 8'h00;
			nlow_cnt <= 8'h00;
			plow_cnt <= 8'h00;
		end
		else
		begin
			flt_r    <= (wr_acc && paddr == OFF_FAULT) ? pwdata[8:0] : flt_r;
			mask_r   <= (wr_acc && paddr == OFF_MASK) ? pwdata[STW-1:0] : mask_r;
			rise_r   <= (wr_acc && paddr == OFF_DEADB) ? pwdata[7:0] : rise_r;
			fall_r   <= (wr_acc && paddr == OFF_DEADB) ? pwdata[15:8] : fall_r;
			nlow_cnt <= pwm_n[0] ? 8'h00 : nlow_cnt + {7'h00, nlow_cnt != 8'hFF};
			plow_cnt <= pwm_p[0] ? 8'h00 : plow_cnt + {7'h00, plow_cnt != 8'hFF};
		end
	end
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_fault_held;
		(fault_in && flt_r[FLT_EN]) [*5];
	endsequence
	sequence s_clear_seen;
		$past(clr_ev) || $past(clr_ev, 2);
	endsequence
	a_no_overlap: assert property (!(|(pwm_p & pwm_n)))
		else $error("both outputs of a pair high");
	a_fault_safe: assert property (s_fault_held |->
		pwm_p == flt_r[3:0] && pwm_n == flt_r[7:4])
		else $error("fault did not force safe levels");
	a_irq_masked: assert property (irq |-> mask_r != '0
		|| $past(mask_r) != '0 || $past(mask_r, 2) != '0)
		else $error("interrupt high with every source masked");
	a_irq_clear_cause: assert property ($fell(irq) |-> s_clear_seen)
		else $error("interrupt dropped without a clear");
	a_dead_rise: assert property ($rose(pwm_p[0]) && !flt_r[FLT_EN]
		|-> nlow_cnt >= rise_r)
		else $error("high side on before rising dead band");
	a_dead_fall: assert property ($rose(pwm_n[0]) && !flt_r[FLT_EN]
		|-> plow_cnt >= fall_r)
		else $error("low side on before falling dead band");
	a_count_width: assert property (rd_cnt |-> prdata[31:16] == 16'h0000)
		else $error("count wider than sixteen bits");
	a_dma_single: assert property (dma_req |=> !dma_req)
		else $error("dma request longer than one cycle");
endmodule
bind pwm_timer pwm_timer_monitor u_pwm_timer_monitor (
	.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.fault_in(fault_in), .pwm_p(pwm_p), .pwm_n(pwm_n), .irq(irq),
	.dma_req(dma_req)
);
`default_nettype wire

// ===== testbench/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
	input  wire logic  mclk,
	output logic [3:0] cap_in,
	output logic       fault_in,
	output logic [5:0] peer_trig,
	output logic       event_subscriber_port_zero,
	output logic       event_subscriber_port_one
);
	// every line rests low until the bench asks for an edge
	initial
	begin
		cap_in = 4'h0;
		fault_in = 1'b0;
		peer_trig = 6'h00;
		event_subscriber_port_zero = 1'b0;
		event_subscriber_port_one = 1'b0;
	end
	// peers share the timer clock, so a two-cycle level is enough
	task automatic pulse(input logic [5:0] p, input logic s0, input logic s1);
	begin
		@(posedge mclk);
		peer_trig <= p;
		event_subscriber_port_zero <= s0;
		event_subscriber_port_one <= s1;
		repeat (2) @(posedge mclk);
		peer_trig <= 6'h00;
		event_subscriber_port_zero <= 1'b0;
		event_subscriber_port_one <= 1'b0;
	end
	endtask
	// held three cycles so the two-stage sync cannot miss it
	task automatic capture(input int ch);
	begin
		@(posedge mclk);
		cap_in <= 4'h1 << ch;
		repeat (3) @(posedge mclk);
		cap_in <= 4'h0;
	end
	endtask
	task automatic set_fault(input logic v);
	begin
		@(posedge mclk);
		fault_in <= v;
	end
	endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import timer_pkg::*;
	logic        mclk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  cap_in, pwm_p, pwm_n;
	logic [5:0]  peer_trig;
	logic        fault_in, sub_zero, sub_one, irq, dma_req, adc_trig, trig_out;
	logic [31:0] q;        // last read data
	logic        bus_err;  // error flag at the access edge
	logic        hit;      // trigger source expected to fire
	logic [4:0]  sel;
	logic [4:0]  sels [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
		5'h10, 5'h11, 5'h06, 5'h12};
	int          error_cnt, n_compared, cyc, d, np, nn, na, nd, nt;
	pwm_timer u_pwm_timer (
		.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cap_in(cap_in),
		.fault_in(fault_in), .peer_trig(peer_trig),
		.event_subscriber_port_zero(sub_zero),
		.event_subscriber_port_one(sub_one), .pwm_p(pwm_p), .pwm_n(pwm_n),
		.irq(irq), .dma_req(dma_req), .adc_trig(adc_trig),
		.primary_trigger_output(trig_out)
	);
	far_side_model u_far_side_model (
		.mclk(mclk), .cap_in(cap_in), .fault_in(fault_in),
		.peer_trig(peer_trig), .event_subscriber_port_zero(sub_zero),
		.event_subscriber_port_one(sub_one)
	);
	always #5 mclk = ~mclk;
	// hang guard, far above the expected run length
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 95000)
		begin
			error_cnt = error_cnt + 1;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
	begin
		if (error_cnt == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_compared = n_compared + 1;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt = error_cnt + 1;
		end
	end
	endtask
	// one bus transfer; request held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] v);
	begin
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		// no wait limit here: only the hang guard ends a stalled transfer
		while (pready !== 1'b1)
			@(posedge mclk);
		q = prdata;
		bus_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	// skips a stale high left over from before a clear
	task automatic wait_rise();
		int n;
	begin
		n = 0;
		while (irq !== 1'b0 && n < 10)
		begin
			@(posedge mclk);
			n = n + 1;
		end
		while (irq !== 1'b1 && n < 400)
		begin
			@(posedge mclk);
			n = n + 1;
		end
		// a missing interrupt counts against the run
		if (irq !== 1'b1)
			error_cnt = error_cnt + 1;
	end
	endtask
	// cycles between two period interrupts, the first read-cleared
	task automatic period();
		int t0;
	begin
		wait_rise();
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		wait_rise();
		t0 = cyc;
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		repeat (3) @(posedge mclk);
		chk({31'h0, irq}, 32'h0000_0000);
		wait_rise();
		d = cyc - t0;
	end
	endtask
	initial
	begin
		mclk = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{cyc, error_cnt, n_compared} = '0;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		apb(1'b0, OFF_LOAD, 32'h0000_0000);
		chk(q, 32'h0000_FFFF);
		apb(1'b0, OFF_COUNT, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		apb(1'b0, 8'h30, 32'h0000_0000);
		chk({bus_err, q[30:0]}, 32'h8000_0000);
		// down count 9..0, three periods per event, pwm on channel 0
		apb(1'b1, OFF_REPEAT, 32'h0000_0002);
		apb(1'b1, OFF_LOAD, 32'h0000_0009);
		apb(1'b1, OFF_DEADB, 32'h0000_0302);
		apb(1'b1, OFF_CC0, 32'h0000_0004);
		apb(1'b1, OFF_CC0 + 8'h10, 32'h0000_0003);
		apb(1'b1, OFF_CCMODE, 32'h0000_0006);
		apb(1'b1, OFF_OUTEN, 32'h0000_0003);
		apb(1'b1, OFF_CTRL, 32'h0000_0019);
		q = 32'h0000_FFFF;
		for (int i = 0; i < 23000 && q > 32'h0000_0009; i++)
			apb(1'b0, OFF_COUNT, 32'h0000_0000);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		repeat (40) @(posedge mclk);
		chk({31'h0, irq}, 32'h0000_0000);
		apb(1'b1, OFF_MASK, 32'h0000_0001);
		period();
		chk(32'(d), 32'h0000_001E);
		// one whole event period: three pwm periods, one period event
		{np, nn, na, nd, nt} = '0;
		repeat (30) @(posedge mclk)
		begin
			np = np + int'(pwm_p[0]);
			nn = nn + int'(pwm_n[0]);
			nd = nd + int'(dma_req);
			na = na + int'(adc_trig);
			nt = nt + int'(trig_out);
		end
		chk(32'(np), 32'h0000_0006);
		chk(32'(nn), 32'h0000_0009);
		chk(32'(nd), 32'h0000_0001);
		chk(32'(na), 32'h0000_0004);
		chk(32'(nt), 32'h0000_0001);
		// a new period is held back until update is enabled
		apb(1'b1, OFF_CTRL, 32'h0000_0009);
		apb(1'b1, OFF_LOAD, 32'h0000_0005);
		period();
		chk(32'(d), 32'h0000_001E);
		apb(1'b1, OFF_CTRL, 32'h0000_0019);
		period();
		chk(32'(d), 32'h0000_0012);
		apb(1'b1, OFF_PRESC, 32'h0000_0001);
		period();
		chk(32'(d), 32'h0000_0024);
		// up: 0 to 5 is six ticks of two cycles
		apb(1'b1, OFF_CTRL, 32'h0000_001B);
		period();
		chk(32'(d), 32'h0000_0024);
		// up-down: 0 up to 5 and back is ten ticks of two cycles
		apb(1'b1, OFF_CTRL, 32'h0000_001D);
		period();
		chk(32'(d), 32'h0000_003C);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		u_far_side_model.capture(1);
		repeat (40) @(posedge mclk);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk({31'h0, q[ST_CC+1]}, 32'h0000_0001);
		chk({31'h0, q[ST_CC+4]}, 32'h0000_0001);
		// every valid source, then two reserved codes with all lines hit
		for (int i = 0; i < 10; i++)
		begin
			sel = sels[i];
			hit = sel < TSEL_PEER || sel == TSEL_SUB0 || sel == TSEL_SUB1;
			apb(1'b1, OFF_CTRL, 32'h0000_0018);
			apb(1'b1, OFF_TRIG, {26'h0, 1'b1, sel});
			apb(1'b0, OFF_STATUS, 32'h0000_0000);
			u_far_side_model.pulse(hit ? 6'h01 << sel : 6'h3F,
				!hit || sel == TSEL_SUB0, !hit || sel == TSEL_SUB1);
			repeat (6) @(posedge mclk);
			apb(1'b0, OFF_STATUS, 32'h0000_0000);
			chk({31'h0, q[ST_TRG]}, {31'h0, hit});
			apb(1'b0, OFF_CTRL, 32'h0000_0000);
			chk({31'h0, q[CTL_EN]}, {31'h0, hit});
		end
		apb(1'b1, OFF_FAULT, 32'h0000_01A5);
		u_far_side_model.set_fault(1'b1);
		repeat (6) @(posedge mclk);
		chk({24'h0, pwm_n, pwm_p}, 32'h0000_00A5);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk({31'h0, q[ST_FLT]}, 32'h0000_0001);
		tally_and_finish();
	end
endmodule
`default_nettype wire
